// file: include/pic_pkg.sv
// Purpose: shared constants for the prioritized interrupt controller
// Assumes: 32-bit apb register bus, one register per aligned word
// Notes: per-source registers are arrays of words starting at a base offset
package pic_pkg;
   localparam int unsigned PIC_NUM_SRC = 8;
   localparam int unsigned PIC_PRIO_W = 8;
   localparam int unsigned PIC_IMPL_BITS = 3;
   localparam int unsigned PIC_GRP_W = 3;
   localparam int unsigned PIC_VTOR_ALIGN_BITS = 10;
   localparam int unsigned PIC_ID_W = 8;
   // register byte offsets
   localparam logic [11:0] PIC_OFF_CTRL = 12'h000;
   localparam logic [11:0] PIC_OFF_MASK = 12'h004;
   localparam logic [11:0] PIC_OFF_GROUP = 12'h008;
   localparam logic [11:0] PIC_OFF_VTOR = 12'h00C;
   localparam logic [11:0] PIC_OFF_TRIG = 12'h010;
   localparam logic [11:0] PIC_OFF_ACK = 12'h014;
   localparam logic [11:0] PIC_OFF_EOI = 12'h018;
   localparam logic [11:0] PIC_OFF_STAT = 12'h01C;
   localparam logic [11:0] PIC_OFF_ENSET = 12'h020;
   localparam logic [11:0] PIC_OFF_ENCLR = 12'h024;
   localparam logic [11:0] PIC_OFF_PNDSET = 12'h028;
   localparam logic [11:0] PIC_OFF_PNDCLR = 12'h02C;
   localparam logic [11:0] PIC_OFF_PRIO = 12'h100;
   localparam logic [31:0] PIC_CTRL_RST = 32'h0000_0000;
   localparam logic [7:0] PIC_NONE = 8'hFF;
   localparam logic [3:0] PIC_LVL_IDLE = 4'h8;
endpackage

// file: hw/pic_top.sv
// Purpose: nested prioritized interrupt controller with apb register access
// Assumes: peripheral lines synchronous to i_clk, core acks and ends handlers
// Notes: apb inserts one wait state; pready pulses in the second access cycle
//
// Overview of operation
// - smaller priority value is more urgent; zero is most urgent.
// - among simultaneous enabled sources, present the most urgent first.
// - arbitration compares only the top three priority bits.
// - nonzero mask blocks sources with priority at or above the threshold.
// - mask threshold zero disables priority masking.
// - mask threshold reads back unchanged.
// - grouping splits priority; only preemption bits allow nesting.
// - grouping values three through seven behave identically.
// - reading grouping returns the written value, not the preemption bit count.
// - software trigger acts exactly like a hardware line assertion.
// - sources are delivered only when individually enabled; else held pending.
// - vector table base is relocatable and 1 kB aligned.
// - global gate blocks the combined request without touching enables.
// - set pending runs the handler when priorities next allow.
// - clear pending discards untaken occurrences.
`timescale 1ns/1ps
`default_nettype none
module pic_top
#(
   parameter int unsigned NUM_SRC = pic_pkg::PIC_NUM_SRC
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // peripheral lines
   input wire logic [NUM_SRC-1:0] i_irq,
   // core side
   output logic o_cpu_irq,
   output logic [31:0] o_vector_addr
);
   import pic_pkg::*;

   // ==========================================================
   // state
   logic [NUM_SRC-1:0] en_q;
   logic [NUM_SRC-1:0] pend_q;
   logic [NUM_SRC-1:0] active_q;
   logic [PIC_PRIO_W-1:0] prio_q [NUM_SRC];
   logic [PIC_PRIO_W-1:0] mask_q;
   logic [PIC_GRP_W-1:0] group_q;
   logic [31-PIC_VTOR_ALIGN_BITS:0] vtor_q;
   logic gate_q;
   logic [NUM_SRC-1:0] irq_prev_q;
   // preemption level of each nested handler, and its stack
   logic [3:0] lvl_stk_q [NUM_SRC+1];
   logic [7:0] id_stk_q [NUM_SRC+1];
   logic [3:0] depth_q;
   logic [31:0] rdata_q;
   logic ready_q;
   logic cpu_irq_q;
   logic [31:0] vec_q;

   // ==========================================================
   // bus decode
   // the access is taken once, on the first access edge; the wait state
   // that follows lets prdata come straight from a flop
   logic acc;
   logic wr;
   logic rd;
   assign acc = i_psel && i_penable && !ready_q;
   assign wr = acc && i_pwrite;
   assign rd = acc && !i_pwrite;

   // one write strobe per register
   logic ctrl_wr;
   logic mask_wr;
   logic group_wr;
   logic vtor_wr;
   logic trig_wr;
   logic ack_req;
   logic eoi_req;
   logic enset_wr;
   logic enclr_wr;
   logic pndset_wr;
   logic pndclr_wr;
   assign ctrl_wr = wr && (i_paddr == PIC_OFF_CTRL);
   assign mask_wr = wr && (i_paddr == PIC_OFF_MASK);
   assign group_wr = wr && (i_paddr == PIC_OFF_GROUP);
   assign vtor_wr = wr && (i_paddr == PIC_OFF_VTOR);
   assign trig_wr = wr && (i_paddr == PIC_OFF_TRIG);
   assign ack_req = wr && (i_paddr == PIC_OFF_ACK);
   assign eoi_req = wr && (i_paddr == PIC_OFF_EOI);
   assign enset_wr = wr && (i_paddr == PIC_OFF_ENSET);
   assign enclr_wr = wr && (i_paddr == PIC_OFF_ENCLR);
   assign pndset_wr = wr && (i_paddr == PIC_OFF_PNDSET);
   assign pndclr_wr = wr && (i_paddr == PIC_OFF_PNDCLR);

   logic is_prio;
   logic [7:0] prio_idx;
   assign is_prio = (i_paddr >= PIC_OFF_PRIO) && (i_paddr[1:0] == 2'b00)
      && ((i_paddr - PIC_OFF_PRIO) < 12'(NUM_SRC * 4));
   assign prio_idx = 8'((i_paddr - PIC_OFF_PRIO) >> 2);

   // ==========================================================
   // arbitration
   // preemption bit count, capped at the implemented bits
   logic [2:0] pre_bits;
   assign pre_bits = (group_q >= 3'(PIC_IMPL_BITS)) ? 3'(PIC_IMPL_BITS) : group_q;

   function automatic logic [2:0] top3(input logic [7:0] p);
      top3 = p[7:5];
   endfunction

   function automatic logic [3:0] pre_lvl(input logic [7:0] p, input logic [2:0] nb);
      logic [2:0] t;
      t = top3(p);
      pre_lvl = {1'b0, t >> (3'(PIC_IMPL_BITS) - nb)};
   endfunction

   logic [NUM_SRC-1:0] cand;
   logic [7:0] win_id;
   logic [2:0] win_p;
   logic win_ok;
   logic [3:0] cur_lvl;
   logic [3:0] win_lvl;
   assign cur_lvl = lvl_stk_q[depth_q];

   // per-source qualification; a source in service cannot compete again
   logic [NUM_SRC-1:0] mask_pass;
   logic mask_off;
   assign mask_off = (mask_q == 8'h00);
   for (genvar g = 0; g < NUM_SRC; g++) begin : g_cand
      // blocked once the value reaches the threshold
      assign mask_pass[g] = mask_off || (top3(prio_q[g]) < top3(mask_q));
      assign cand[g] = pend_q[g] && en_q[g] && !active_q[g] && mask_pass[g];
   end

   always_comb begin
      win_id = PIC_NONE;
      win_p = 3'h7;
      win_ok = 1'b0;
      for (int i = 0; i < NUM_SRC; i++) begin
         // lower value wins, lowest index breaks ties
         if (cand[i] && (!win_ok || top3(prio_q[i]) < win_p)) begin
            win_ok = 1'b1;
            win_p = top3(prio_q[i]);
            win_id = 8'(i);
         end
      end
   end
   assign win_lvl = win_ok ? pre_lvl({win_p, 5'h00}, pre_bits) : PIC_LVL_IDLE;

   // only a strictly more urgent preemption level nests
   logic take_ok;
   assign take_ok = win_ok && (win_lvl < cur_lvl) && (depth_q < 4'(NUM_SRC));

   // a take with nothing preemptable, or an end at depth zero, is dropped
   logic ack_wr;
   logic eoi_wr;
   assign ack_wr = ack_req && take_ok;
   assign eoi_wr = eoi_req && (depth_q != 4'h0);

   // ==========================================================
   // pending, enable, active
   // line history resets to the idle level, so a line already high at reset is seen as an edge
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         irq_prev_q <= '0;
      end else begin
         irq_prev_q <= i_irq;
      end
   end

   // set and clear requests per source
   logic [NUM_SRC-1:0] pend_set;
   logic [NUM_SRC-1:0] pend_clr;
   for (genvar g = 0; g < NUM_SRC; g++) begin : g_pend
      // trigger acts like a line edge; set pending
      assign pend_set[g] = (i_irq[g] && !irq_prev_q[g])
         || (trig_wr && (i_pwdata[PIC_ID_W-1:0] == PIC_ID_W'(g)))
         || (pndset_wr && i_pwdata[g]);
      assign pend_clr[g] = (pndclr_wr && i_pwdata[g])
         || (ack_wr && (win_id == PIC_ID_W'(g)));
   end

   // a set beats a clear in the same cycle, so no edge is lost
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pend_q <= '0;
      end else begin
         pend_q <= pend_set | (pend_q & ~pend_clr);
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         en_q <= '0;
      end else if (enset_wr) begin
         en_q <= en_q | i_pwdata[NUM_SRC-1:0];
      end else if (enclr_wr) begin
         en_q <= en_q & ~i_pwdata[NUM_SRC-1:0];
      end
   end

   // nesting depth; entry zero of the stacks is the idle thread level
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         depth_q <= 4'h0;
      end else if (ack_wr) begin
         depth_q <= depth_q + 4'h1;
      end else if (eoi_wr) begin
         depth_q <= depth_q - 4'h1;
      end
   end

   // handlers in service; an end write retires only the innermost one
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         active_q <= '0;
      end else if (ack_wr) begin
         active_q[win_id[2:0]] <= 1'b1;
      end else if (eoi_wr) begin
         active_q[id_stk_q[depth_q][2:0]] <= 1'b0;
      end
   end

   // level and id of each taken handler
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         for (int k = 0; k <= NUM_SRC; k++) begin
            lvl_stk_q[k] <= PIC_LVL_IDLE;
            id_stk_q[k] <= PIC_NONE;
         end
      end else if (ack_wr) begin
         lvl_stk_q[depth_q + 4'h1] <= win_lvl;
         id_stk_q[depth_q + 4'h1] <= win_id;
      end
   end

   // ==========================================================
   // configuration registers
   // global gate
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         gate_q <= 1'b0;
      end else if (ctrl_wr) begin
         gate_q <= i_pwdata[0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         mask_q <= 8'h00;
      end else if (mask_wr) begin
         mask_q <= i_pwdata[PIC_PRIO_W-1:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         group_q <= 3'h0;
      end else if (group_wr) begin
         group_q <= i_pwdata[PIC_GRP_W-1:0];
      end
   end

   // low bits of the base are not stored, so they read as zero
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         vtor_q <= '0;
      end else if (vtor_wr) begin
         vtor_q <= i_pwdata[31:PIC_VTOR_ALIGN_BITS];
      end
   end

   for (genvar g = 0; g < NUM_SRC; g++) begin : g_prio
      always_ff @(posedge i_clk) begin
         if (!i_rst_n) begin
            prio_q[g] <= 8'h00;
         end else if (wr && is_prio && prio_idx == 8'(g)) begin
            prio_q[g] <= i_pwdata[7:0];
         end
      end
   end

   // ==========================================================
   // read path
   logic [31:0] rmux;
   logic valid_addr;
   always_comb begin
      rmux = 32'h0000_0000;
      valid_addr = 1'b1;
      if (is_prio) begin
         rmux = {24'h000000, prio_q[prio_idx[2:0]]};
      end else begin
         case (i_paddr)
            PIC_OFF_CTRL: rmux = {31'h0, gate_q};
            PIC_OFF_MASK: rmux = {24'h0, mask_q};
            PIC_OFF_GROUP: rmux = {29'h0, group_q};
            PIC_OFF_VTOR: rmux = {vtor_q, 10'h000};
            PIC_OFF_STAT: rmux = {win_id, 4'h0, depth_q, 7'h0, take_ok, 8'(id_stk_q[depth_q])};
            PIC_OFF_ENSET, PIC_OFF_ENCLR: rmux = 32'(en_q);
            PIC_OFF_PNDSET, PIC_OFF_PNDCLR: rmux = 32'(pend_q);
            PIC_OFF_TRIG, PIC_OFF_ACK, PIC_OFF_EOI: rmux = 32'h0000_0000;
            default: valid_addr = 1'b0;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ready_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else begin
         ready_q <= i_psel && i_penable && !ready_q;
         o_pslverr <= acc && !valid_addr;
         if (rd) begin
            rdata_q <= rmux;
         end
      end
   end
   assign o_pready = ready_q;
   assign o_prdata = rdata_q;

   // ==========================================================
   // core request
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cpu_irq_q <= 1'b0;
         vec_q <= 32'h0000_0000;
      end else begin
         cpu_irq_q <= take_ok && gate_q && !ack_wr;
         // vector fetch address from relocated base
         vec_q <= {vtor_q, 10'h000} + {22'h0, win_id, 2'b00};
      end
   end
   assign o_cpu_irq = cpu_irq_q;
   assign o_vector_addr = vec_q;
endmodule
`default_nettype wire

// file: verification/pic_top_assertions.sv
// Purpose: port-level checker for the interrupt controller
// Assumes: apb answer one cycle after the first access edge
// Notes: bound into pic_top at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module pic_top_assertions #(
   parameter int unsigned NUM_SRC = 8
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_cpu_irq,
   input wire logic [31:0] o_vector_addr
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   property p_rdy_time; i_psel && i_penable && !o_pready |=> o_pready; endproperty
   a_rdy_time: assert property (p_rdy_time) else $error("pready late");
   property p_rdy_pulse; o_pready |=> !o_pready; endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held");
   property p_rdy_cause; o_pready |-> $past(i_psel && i_penable); endproperty
   a_rdy_cause: assert property (p_rdy_cause) else $error("pready unasked");
   property p_err_rdy; o_pslverr |-> o_pready; endproperty
   a_err_rdy: assert property (p_err_rdy) else $error("pslverr alone");
   property p_quiet; $past(!i_rst_n) |-> !o_cpu_irq && !o_pready && o_prdata == 32'h0; endproperty
   a_quiet: assert property (p_quiet) else $error("outputs busy after reset");
   property p_vec_align; o_vector_addr[1:0] == 2'h0; endproperty
   a_vec_align: assert property (p_vec_align) else $error("vector unaligned");
   property p_vec_range; o_vector_addr[9:5] == 5'h0 || o_vector_addr[9:0] == 10'h3FC; endproperty
   a_vec_range: assert property (p_vec_range) else $error("vector index off");
   property p_irq_win; o_cpu_irq |-> o_vector_addr[9:0] != 10'h3FC; endproperty
   a_irq_win: assert property (p_irq_win) else $error("request with no winner");
endmodule
bind pic_top pic_top_assertions #(.NUM_SRC(NUM_SRC)) u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_psel(i_psel), .i_penable(i_penable), .o_prdata(o_prdata), .o_pready(o_pready),
   .o_pslverr(o_pslverr), .o_cpu_irq(o_cpu_irq), .o_vector_addr(o_vector_addr));
`default_nettype wire

// file: verification/pic_core_model.sv
// Purpose: processor side that sees the combined request
// Assumes: the bench performs the take and end writes for it
// Notes: one cycle of sampling delay, like a real core input
`timescale 1ns/1ps
`default_nettype none
module pic_core_model (
   input wire logic i_clk,
   input wire logic i_cpu_irq,
   output logic o_want
);
   always_ff @(posedge i_clk) begin
      o_want <= i_cpu_irq;
   end
endmodule
`default_nettype wire

// file: verification/tb.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: eight sources, apb master waits for pready
// Notes: read notes queue up and a monitor checks them on pready
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pic_pkg::*;
   logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
   logic [11:0] pa = 12'h0;
   logic [31:0] pwd = 32'h0, r, vb;
   logic [7:0] irq = 8'h0;
   logic [7:0] pt [5] = '{8'hE0, 8'h3F, 8'h20, 8'h40, 8'h00};
   wire logic [31:0] prd, vec;
   wire logic rdy, err, cirq, want;
   logic [64:0] exp_q[$];
   logic [64:0] e;
   int fails = 0, comparisons = 0, i;
   always #20 clk = ~clk;
   pic_top #(.NUM_SRC(8)) uut (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy),
      .o_pslverr(err), .i_irq(irq), .o_cpu_irq(cirq), .o_vector_addr(vec));
   pic_core_model core (.i_clk(clk), .i_cpu_irq(cirq), .o_want(want));
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      comparisons++;
      if (g !== x) begin
         fails++;
         $display("wrong value at %0t: got %h want %h", $time, g, x);
      end
   endtask
   always @(posedge clk) if (rdy === 1'h1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk({31'h0, err}, {31'h0, e[64]});
      chk(prd & e[63:32], e[31:0]);
   end
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [64:0] x);
      exp_q.push_back(x);
      psel <= 1'h1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'h1;
      @(posedge clk);
      // only the watchdog ends a wait for pready
      while (rdy !== 1'h1) @(posedge clk);
      psel <= 1'h0;
      pen <= 1'h0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'h1, a, d, 65'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
      bus(1'h0, a, 32'h0, {1'h0, m, v});
   endtask
   task automatic quiet();
      repeat (6) @(posedge clk);
      chk({31'h0, want}, 32'h0);
   endtask
   // waits for the request, checks winner and vector, then takes it
   task automatic take(input logic [7:0] id);
      int n;
      repeat (3) @(posedge clk);
      for (n = 0; n < 40 && want !== 1'h1; n++) @(posedge clk);
      chk({31'h0, want}, 32'h1);
      chk(vec, vb | {22'h0, id, 2'h0});
      rd(PIC_OFF_STAT, 32'hFF00_0000, {id, 24'h0});
      wr(PIC_OFF_ACK, 32'h0);
   endtask
   task automatic pulse(input logic [7:0] m);
      irq <= m;
      @(posedge clk);
      irq <= 8'h0;
   endtask
   task automatic end_sim();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      end_sim();
   end
   initial begin
      void'($urandom(32'haf80));
      repeat (4) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      rd(PIC_OFF_CTRL, 32'hFFFF_FFFF, PIC_CTRL_RST);
      bus(1'h0, 12'h030, 32'h0, {1'h1, 64'h0}); // unmapped refused
      for (i = 0; i < 8; i++) begin
         r = $urandom;
         wr(PIC_OFF_PRIO + 12'(4 * i), r);
         rd(PIC_OFF_PRIO + 12'(4 * i), 32'hFF, r & 32'hFF);
         wr(PIC_OFF_GROUP, i);
         rd(PIC_OFF_GROUP, 32'h7, i);
      end
      wr(PIC_OFF_MASK, r);
      rd(PIC_OFF_MASK, 32'hFF, r & 32'hFF);
      r = $urandom;
      vb = r & 32'hFFFF_FC00;
      wr(PIC_OFF_VTOR, r);
      rd(PIC_OFF_VTOR, 32'hFFFF_FFFF, vb);
      $display("test registers done");
      wr(PIC_OFF_MASK, 32'h0);
      for (i = 0; i < 5; i++) wr(PIC_OFF_PRIO + 12'(4 * i), pt[i]);
      wr(PIC_OFF_ENSET, 32'h0F);
      wr(PIC_OFF_CTRL, 32'h1);
      pulse(8'h06);
      take(8'd1);
      wr(PIC_OFF_EOI, 32'h0);
      take(8'd2);
      wr(PIC_OFF_EOI, 32'h0);
      wr(PIC_OFF_TRIG, 32'h4);
      quiet();
      wr(PIC_OFF_PNDCLR, 32'h10);
      wr(PIC_OFF_ENSET, 32'h1F);
      quiet();
      wr(PIC_OFF_PNDSET, 32'h10);
      take(8'd4);
      wr(PIC_OFF_EOI, 32'h0);
      wr(PIC_OFF_CTRL, 32'h0);
      wr(PIC_OFF_TRIG, 32'h0);
      pulse(8'h10);
      quiet();
      rd(PIC_OFF_ENSET, 32'hFF, 32'h1F);
      wr(PIC_OFF_CTRL, 32'h1);
      take(8'd4);
      quiet();
      wr(PIC_OFF_EOI, 32'h0);
      take(8'd0);
      wr(PIC_OFF_EOI, 32'h0);
      $display("test arbitration done");
      wr(PIC_OFF_MASK, 32'h20);
      wr(PIC_OFF_PNDSET, 32'h03);
      quiet();
      wr(PIC_OFF_MASK, 32'h40);
      take(8'd1);
      wr(PIC_OFF_EOI, 32'h0);
      quiet();
      wr(PIC_OFF_MASK, 32'h0);
      take(8'd0);
      wr(PIC_OFF_EOI, 32'h0);
      $display("test masking done");
      for (i = 0; i < 8; i++) begin
         wr(PIC_OFF_GROUP, i);
         wr(PIC_OFF_PNDSET, 32'h08);
         take(8'd3);
         wr(PIC_OFF_PNDSET, 32'h04);
         repeat (6) @(posedge clk);
         chk({31'h0, want}, {31'h0, i >= 2});
         if (i < 2)
            wr(PIC_OFF_EOI, 32'h0);
         take(8'd2);
         wr(PIC_OFF_EOI, 32'h0);
         if (i >= 2)
            wr(PIC_OFF_EOI, 32'h0);
      end
      $display("test nesting done");
      end_sim();
   end
endmodule
`default_nettype wire
